/* logic/rtcc_core.sv */
// RTC core: timer, calendar, elapsed and periodic sections behind AXI4-Lite
`default_nettype none
module rtcc_core
	import rtcc_pkg::*;
#(
	parameter int unsigned HUND_CYCLES = ELAPSED_STEP_CYC,
	parameter int unsigned MS_CYCLES = PERIODIC_STEP_CYC
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wdt_rst_n,
	input wire logic ref_clk_in,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic one_hz_tick,
	output logic [NUM_AL-1:0] pm_match_r,
	output logic [NUM_AL-1:0] irq_req_r
);
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[8*i +: 8] = nw[8*i +: 8];
		return r;
	endfunction : merge

	function automatic logic [4:0] days_in(input logic [3:0] mon, input logic [11:0] yr);
		logic [4:0] d;
		case (mon)
			4'h4, 4'h6, 4'h9, 4'hb: d = 5'h1e;
			4'h2: d = (yr[1:0] == 2'h0) ? 5'h1d : 5'h1c;
			default: d = 5'h1f;
		endcase
		return d;
	endfunction : days_in

	logic rst_ctl;
	logic tick_pulse;
	logic [15:0] trim_r;
	logic [31:0] seconds_counter_r, seconds_alarm_r, sec_nxt;
	rtcc_time_t calendar_time_counter_r, cal_time_nxt;
	rtcc_date_t calendar_date_counter_r, cal_date_nxt;
	rtcc_time_t calendar_time_alarm_a_r, calendar_time_alarm_b_r;
	rtcc_date_t calendar_date_alarm_a_r, calendar_date_alarm_b_r;
	rtcc_elapsed_t elapsed_counter_r, elapsed_alarm_a_r, elapsed_alarm_b_r, el_nxt;
	logic [15:0] periodic_counter_r, periodic_alarm_r, per_nxt;
	logic [PRE_W-1:0] el_pre_r, per_pre_r;
	logic el_step, per_step;
	logic [NUM_AL-1:0] flag_r, en_r, hit, flag_clr;
	logic [1:0] cen_r;
	logic [31:0] status_val, status_w, rd_val;
	logic rd_ok, wr_ok;
	logic aw_hold_r, w_hold_r, wr_go;
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;

	// no other reset input exists, so sleep-exit and GPIO resets cannot reach the core
	assign rst_ctl = !aresetn || !wdt_rst_n;

	rtcc_tick_gen u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.ref_clk_in(ref_clk_in),
		.trim_div(trim_r),
		.tick_pulse_r(tick_pulse),
		.one_hz_tick_r(one_hz_tick)
	);

	// Write channel: address and data may arrive in either order
	assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
	always_ff @(posedge aclk)
	begin
		if (rst_ctl)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			awaddr_r <= '0;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awaddr_r <= s_axi_awaddr;
				aw_hold_r <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
				w_hold_r <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	assign status_val = {14'h0, cen_r, 2'h0, en_r, 2'h0, flag_r};
	assign status_w = merge(status_val, wdata_r, wstrb_r);
	always_comb
	begin
		wr_ok = 1'b1;
		case (awaddr_r)
			OFF_SEC_CNT, OFF_SEC_ALM, OFF_STATUS, OFF_TRIM, OFF_CAL_TIME, OFF_CAL_DATE,
			OFF_TIME_ALM_A, OFF_DATE_ALM_A, OFF_TIME_ALM_B, OFF_DATE_ALM_B, OFF_EL_CNT,
			OFF_EL_ALM_A, OFF_EL_ALM_B, OFF_PER_CNT, OFF_PER_ALM: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	// Read channel: data registered on the same edge that takes the address
	always_comb
	begin
		rd_ok = 1'b1;
		case (s_axi_araddr)
			OFF_SEC_CNT: rd_val = seconds_counter_r;
			OFF_SEC_ALM: rd_val = seconds_alarm_r;
			OFF_STATUS: rd_val = status_val;
			OFF_TRIM: rd_val = {16'h0, trim_r};
			OFF_CAL_TIME: rd_val = {9'h0, calendar_time_counter_r};
			OFF_CAL_DATE: rd_val = {11'h0, calendar_date_counter_r};
			OFF_TIME_ALM_A: rd_val = {9'h0, calendar_time_alarm_a_r};
			OFF_DATE_ALM_A: rd_val = {11'h0, calendar_date_alarm_a_r};
			OFF_TIME_ALM_B: rd_val = {9'h0, calendar_time_alarm_b_r};
			OFF_DATE_ALM_B: rd_val = {11'h0, calendar_date_alarm_b_r};
			OFF_EL_CNT: rd_val = {8'h0, elapsed_counter_r};
			OFF_EL_ALM_A: rd_val = {8'h0, elapsed_alarm_a_r};
			OFF_EL_ALM_B: rd_val = {8'h0, elapsed_alarm_b_r};
			OFF_PER_CNT: rd_val = {16'h0, periodic_counter_r};
			OFF_PER_ALM: rd_val = {16'h0, periodic_alarm_r};
			default:
			begin
				rd_val = 32'h0;
				rd_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (rst_ctl)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			trim_r <= TRIM_RST;
		// A write cut short by a watchdog reset must not reach trim
		else if (wdt_rst_n && wr_go && awaddr_r == OFF_TRIM)
			trim_r <= 16'(merge({16'h0, trim_r}, wdata_r, wstrb_r));
	end

	assign sec_nxt = seconds_counter_r + 32'h1;
	always_ff @(posedge aclk)
	begin
		if (rst_ctl)
		begin
			seconds_counter_r <= SEC_RST;
			seconds_alarm_r <= SEC_RST;
		end
		else
		begin
			if (wr_go && awaddr_r == OFF_SEC_CNT)
				seconds_counter_r <= merge(seconds_counter_r, wdata_r, wstrb_r);
			else if (tick_pulse)
				seconds_counter_r <= sec_nxt;
			if (wr_go && awaddr_r == OFF_SEC_ALM)
				seconds_alarm_r <= merge(seconds_alarm_r, wdata_r, wstrb_r);
		end
	end

	// calendar rollover
	// Leap years are taken as every fourth year; century rules are not applied
	always_comb
	begin
		cal_time_nxt = calendar_time_counter_r;
		cal_date_nxt = calendar_date_counter_r;
		cal_time_nxt.sec = cal_time_nxt.sec + 6'h1;
		if (calendar_time_counter_r.sec >= 6'h3b)
		begin
			cal_time_nxt.sec = 6'h0;
			cal_time_nxt.min = cal_time_nxt.min + 6'h1;
			if (calendar_time_counter_r.min >= 6'h3b)
			begin
				cal_time_nxt.min = 6'h0;
				cal_time_nxt.hour = cal_time_nxt.hour + 5'h1;
				if (calendar_time_counter_r.hour >= 5'h17)
				begin
					cal_time_nxt.hour = 5'h0;
					cal_time_nxt.dow = (cal_time_nxt.dow >= 3'h7) ? 3'h1 : cal_time_nxt.dow + 3'h1;
					if (cal_date_nxt.dom >= days_in(cal_date_nxt.month, cal_date_nxt.year))
					begin
						cal_date_nxt.dom = 5'h1;
						cal_time_nxt.wom = 3'h1;
						if (cal_date_nxt.month >= 4'hc)
						begin
							cal_date_nxt.month = 4'h1;
							cal_date_nxt.year = cal_date_nxt.year + 12'h1;
						end
						else
							cal_date_nxt.month = cal_date_nxt.month + 4'h1;
					end
					else
					begin
						cal_date_nxt.dom = cal_date_nxt.dom + 5'h1;
						if (cal_time_nxt.dow == 3'h1 && cal_time_nxt.wom < 3'h5)
							cal_time_nxt.wom = cal_time_nxt.wom + 3'h1;
					end
				end
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (rst_ctl)
		begin
			calendar_time_counter_r <= TIME_RST;
			calendar_date_counter_r <= DATE_RST;
			calendar_time_alarm_a_r <= TIME_RST;
			calendar_date_alarm_a_r <= DATE_RST;
			calendar_time_alarm_b_r <= TIME_RST;
			calendar_date_alarm_b_r <= DATE_RST;
		end
		else
		begin
			if (wr_go && awaddr_r == OFF_CAL_TIME)
				calendar_time_counter_r <= 23'(merge({9'h0, calendar_time_counter_r}, wdata_r,
					wstrb_r));
			else if (tick_pulse)
				calendar_time_counter_r <= cal_time_nxt;
			if (wr_go && awaddr_r == OFF_CAL_DATE)
				calendar_date_counter_r <= 21'(merge({11'h0, calendar_date_counter_r}, wdata_r,
					wstrb_r));
			else if (tick_pulse)
				calendar_date_counter_r <= cal_date_nxt;
			if (wr_go && awaddr_r == OFF_TIME_ALM_A)
				calendar_time_alarm_a_r <= 23'(merge({9'h0, calendar_time_alarm_a_r},
					wdata_r, wstrb_r));
			if (wr_go && awaddr_r == OFF_DATE_ALM_A)
				calendar_date_alarm_a_r <= 21'(merge({11'h0, calendar_date_alarm_a_r},
					wdata_r, wstrb_r));
			if (wr_go && awaddr_r == OFF_TIME_ALM_B)
				calendar_time_alarm_b_r <= 23'(merge({9'h0, calendar_time_alarm_b_r},
					wdata_r, wstrb_r));
			if (wr_go && awaddr_r == OFF_DATE_ALM_B)
				calendar_date_alarm_b_r <= 21'(merge({11'h0, calendar_date_alarm_b_r},
					wdata_r, wstrb_r));
		end
	end

	assign el_step = cen_r[CEN_EL] && (el_pre_r == PRE_W'(HUND_CYCLES - 1));
	assign per_step = cen_r[CEN_PER] && (per_pre_r == PRE_W'(MS_CYCLES - 1));
	always_ff @(posedge aclk)
	begin
		if (rst_ctl)
		begin
			el_pre_r <= '0;
			per_pre_r <= '0;
		end
		else
		begin
			if (cen_r[CEN_EL])
				el_pre_r <= el_step ? '0 : el_pre_r + PRE_W'(1);
			if (cen_r[CEN_PER])
				per_pre_r <= per_step ? '0 : per_pre_r + PRE_W'(1);
		end
	end

	always_comb
	begin
		el_nxt = elapsed_counter_r;
		el_nxt.hund = el_nxt.hund + 7'h1;
		if (elapsed_counter_r.hund >= 7'h63)
		begin
			el_nxt.hund = 7'h0;
			el_nxt.sec = el_nxt.sec + 6'h1;
			if (elapsed_counter_r.sec >= 6'h3b)
			begin
				el_nxt.sec = 6'h0;
				el_nxt.min = el_nxt.min + 6'h1;
				if (elapsed_counter_r.min >= 6'h3b)
				begin
					el_nxt.min = 6'h0;
					el_nxt.hour = el_nxt.hour + 5'h1;
				end
			end
		end
	end

	assign per_nxt = periodic_counter_r + 16'h1;
	always_ff @(posedge aclk)
	begin
		if (rst_ctl)
		begin
			elapsed_counter_r <= '0;
			elapsed_alarm_a_r <= '0;
			elapsed_alarm_b_r <= '0;
			periodic_counter_r <= 16'h0;
			periodic_alarm_r <= 16'h0;
		end
		else
		begin
			if (wr_go && awaddr_r == OFF_EL_CNT)
				elapsed_counter_r <= 24'(merge({8'h0, elapsed_counter_r}, wdata_r, wstrb_r));
			else if (el_step)
				elapsed_counter_r <= el_nxt;
			if (wr_go && awaddr_r == OFF_EL_ALM_A)
				elapsed_alarm_a_r <= 24'(merge({8'h0, elapsed_alarm_a_r}, wdata_r, wstrb_r));
			if (wr_go && awaddr_r == OFF_EL_ALM_B)
				elapsed_alarm_b_r <= 24'(merge({8'h0, elapsed_alarm_b_r}, wdata_r, wstrb_r));
			if (wr_go && awaddr_r == OFF_PER_CNT)
				periodic_counter_r <= 16'(merge({16'h0, periodic_counter_r}, wdata_r, wstrb_r));
			else if (per_step)
				periodic_counter_r <= hit[AL_PER] ? 16'h0 : per_nxt;
			if (wr_go && awaddr_r == OFF_PER_ALM)
				periodic_alarm_r <= 16'(merge({16'h0, periodic_alarm_r}, wdata_r, wstrb_r));
		end
	end

	always_comb
	begin
		hit = '0;
		hit[AL_TIMER] = tick_pulse && (sec_nxt == seconds_alarm_r);
		hit[AL_CAL_A] = tick_pulse && ({cal_time_nxt, cal_date_nxt} ==
			{calendar_time_alarm_a_r, calendar_date_alarm_a_r});
		hit[AL_CAL_B] = tick_pulse && ({cal_time_nxt, cal_date_nxt} ==
			{calendar_time_alarm_b_r, calendar_date_alarm_b_r});
		hit[AL_EL_A] = el_step && (el_nxt == elapsed_alarm_a_r);
		hit[AL_EL_B] = el_step && (el_nxt == elapsed_alarm_b_r);
		hit[AL_PER] = per_step && (per_nxt == periodic_alarm_r);
	end

	assign flag_clr = (wr_go && awaddr_r == OFF_STATUS) ?
		NUM_AL'(merge(32'h0, wdata_r, wstrb_r) >> FLAG_LSB) : '0;

	// flags are sticky, a new enabled match wins over a clear
	always_ff @(posedge aclk)
	begin
		if (rst_ctl)
		begin
			pm_match_r <= '0;
			flag_r <= '0;
			irq_req_r <= '0;
		end
		else
		begin
			pm_match_r <= hit;
			flag_r <= (flag_r & ~flag_clr) | (hit & en_r);
			irq_req_r <= flag_r;
		end
	end

	// enables set by software after the alarm is loaded
	always_ff @(posedge aclk)
	begin
		if (rst_ctl)
		begin
			en_r <= '0;
			cen_r <= 2'h0;
		end
		else if (wr_go && awaddr_r == OFF_STATUS)
		begin
			en_r <= status_w[EN_LSB +: NUM_AL];
			cen_r <= status_w[CEN_LSB +: 2];
		end
	end

	chk_flag_needs_en: assert property (@(posedge aclk) disable iff (rst_ctl)
		$rose(flag_r[AL_TIMER]) |-> $past(en_r[AL_TIMER]) && $past(hit[AL_TIMER]))
		else $error("timer flag set without enable and match");
	chk_pm_on_match: assert property (@(posedge aclk) disable iff (rst_ctl)
		tick_pulse && sec_nxt == seconds_alarm_r |=> pm_match_r[AL_TIMER])
		else $error("timer match not signalled to power manager");
	chk_sec_increment: assert property (@(posedge aclk) disable iff (rst_ctl)
		tick_pulse && !(wr_go && awaddr_r == OFF_SEC_CNT)
		|=> seconds_counter_r == $past(seconds_counter_r) + 32'h1)
		else $error("seconds counter did not step by one");
	chk_w1c_clear: assert property (@(posedge aclk) disable iff (rst_ctl)
		flag_clr[AL_TIMER] && !hit[AL_TIMER] |=> !flag_r[AL_TIMER])
		else $error("write one did not clear timer flag");
	chk_flag_sticky: assert property (@(posedge aclk) disable iff (rst_ctl)
		flag_r[AL_PER] && !flag_clr[AL_PER] |=> flag_r[AL_PER])
		else $error("periodic flag dropped without clear");
	chk_irq_follow: assert property (@(posedge aclk) disable iff (rst_ctl)
		flag_r != '0 |=> irq_req_r == $past(flag_r))
		else $error("interrupt request does not follow flags");
	chk_elapsed_hold: assert property (@(posedge aclk) disable iff (rst_ctl)
		!cen_r[CEN_EL] && !(wr_go && awaddr_r == OFF_EL_CNT) |=> $stable(elapsed_counter_r))
		else $error("elapsed counter moved while disabled");
	chk_trim_keep: assert property (@(posedge aclk) disable iff (!aresetn)
		!wdt_rst_n |=> $stable(trim_r))
		else $error("watchdog reset changed trim");
	chk_wdt_reset: assert property (@(posedge aclk) disable iff (!aresetn)
		!wdt_rst_n |=> flag_r == '0 && en_r == '0 && seconds_counter_r == SEC_RST)
		else $error("watchdog reset did not clear core state");
endmodule : rtcc_core
`default_nettype wire

/* logic/rtcc_pkg.sv */
// Package: constants, register map and carrier types of the RTC core
`default_nettype none
package rtcc_pkg;
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned REF_HZ = 32768;
	localparam int unsigned ELAPSED_STEP_MS = 10;
	localparam int unsigned PERIODIC_STEP_MS = 1;
	localparam int unsigned ELAPSED_STEP_CYC = CLK_HZ / 1000 * ELAPSED_STEP_MS;
	localparam int unsigned PERIODIC_STEP_CYC = CLK_HZ / 1000 * PERIODIC_STEP_MS;
	localparam int PRE_W = 21;
	localparam int ADDR_W = 8;
	localparam int NUM_AL = 6;

	localparam logic [7:0] OFF_SEC_CNT = 8'h00;
	localparam logic [7:0] OFF_SEC_ALM = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_TRIM = 8'h0c;
	localparam logic [7:0] OFF_CAL_TIME = 8'h10;
	localparam logic [7:0] OFF_CAL_DATE = 8'h14;
	localparam logic [7:0] OFF_TIME_ALM_A = 8'h18;
	localparam logic [7:0] OFF_DATE_ALM_A = 8'h1c;
	localparam logic [7:0] OFF_TIME_ALM_B = 8'h20;
	localparam logic [7:0] OFF_DATE_ALM_B = 8'h24;
	localparam logic [7:0] OFF_EL_CNT = 8'h28;
	localparam logic [7:0] OFF_EL_ALM_A = 8'h2c;
	localparam logic [7:0] OFF_EL_ALM_B = 8'h30;
	localparam logic [7:0] OFF_PER_CNT = 8'h34;
	localparam logic [7:0] OFF_PER_ALM = 8'h38;

	// Alarm index inside the flag, enable and match vectors
	localparam int AL_TIMER = 0;
	localparam int AL_CAL_A = 1;
	localparam int AL_CAL_B = 2;
	localparam int AL_EL_A = 3;
	localparam int AL_EL_B = 4;
	localparam int AL_PER = 5;
	localparam int FLAG_LSB = 0;
	localparam int EN_LSB = 8;
	localparam int CEN_LSB = 16;
	localparam int CEN_EL = 0;
	localparam int CEN_PER = 1;

	localparam logic [15:0] TRIM_RST = 16'h7fff;
	localparam logic [31:0] SEC_RST = 32'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [2:0] wom;
		logic [2:0] dow;
		logic [4:0] hour;
		logic [5:0] min;
		logic [5:0] sec;
	} rtcc_time_t;

	typedef struct packed {
		logic [11:0] year;
		logic [3:0] month;
		logic [4:0] dom;
	} rtcc_date_t;

	typedef struct packed {
		logic [4:0] hour;
		logic [5:0] min;
		logic [5:0] sec;
		logic [6:0] hund;
	} rtcc_elapsed_t;

	localparam rtcc_time_t TIME_RST = '{wom: 3'h1, dow: 3'h1, hour: 5'h0, min: 6'h0, sec: 6'h0};
	localparam rtcc_date_t DATE_RST = '{year: 12'h0, month: 4'h1, dom: 5'h1};
endpackage : rtcc_pkg
`default_nettype wire

/* logic/rtcc_tick_gen.sv */
// Trimmed one-hertz tick generator driven by the low-frequency reference
`default_nettype none
module rtcc_tick_gen
	import rtcc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ref_clk_in,
	input wire logic [15:0] trim_div,
	output logic tick_pulse_r,
	output logic one_hz_tick_r
);
	logic ref_q_r;
	logic ref_arm_r;
	logic [15:0] div_cnt_r;
	logic ref_rise;

	// A reference already high at reset release must not count as an edge
	assign ref_rise = ref_arm_r & ref_clk_in & ~ref_q_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ref_q_r <= 1'b0;
			ref_arm_r <= 1'b0;
		end
		else
		begin
			ref_q_r <= ref_clk_in;
			ref_arm_r <= 1'b1;
		end
	end

	// whole reference periods
	// Counting reference edges keeps each second exact to one reference period
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			div_cnt_r <= 16'h0;
			tick_pulse_r <= 1'b0;
		end
		else
		begin
			tick_pulse_r <= 1'b0;
			if (ref_rise)
			begin
				if (div_cnt_r >= trim_div)
				begin
					div_cnt_r <= 16'h0;
					tick_pulse_r <= 1'b1;
				end
				else
					div_cnt_r <= div_cnt_r + 16'h1;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			one_hz_tick_r <= 1'b0;
		else
			one_hz_tick_r <= (div_cnt_r <= (trim_div >> 1));
	end
endmodule : rtcc_tick_gen
`default_nettype wire

/* testbench/rtcc_far_model.sv */
// Far-side model: reference clock source and power manager event sink
`default_nettype none
module rtcc_far_model
	import rtcc_pkg::*;
#(
	parameter int REF_HALF = 4
)
(
	input wire logic aclk,
	input wire logic [NUM_AL-1:0] pm_match_r,
	output logic ref_clk_in,
	output var int match_cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	int half = 0;
	logic ref_r = 1'b0;
	// Reference sped up so a trimmed second lasts a few dozen cycles
	always @(posedge aclk)
	begin
		half <= (half == REF_HALF - 1) ? 0 : half + 1;
		if (half == REF_HALF - 1)
			ref_r <= !ref_r;
	end
	assign ref_clk_in = ref_r;
	initial
	begin
		match_cnt = 0;
		forever
		begin
			// Mid-cycle sample: the count is settled before the bench reads it
			@(negedge aclk);
			if (pm_match_r[AL_TIMER] === 1'b1)
				match_cnt++;
		end
	end
endmodule : rtcc_far_model
`default_nettype wire

/* testbench/rtcc_core_test.sv */
// Self-checking bench for the RTC core over AXI4-Lite
`default_nettype none
module rtcc_core_test
	import rtcc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, wdt_rst_n, ref_clk_in, one_hz_tick, hit;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp, rs;
	logic [NUM_AL-1:0] pm_match_r, irq_req_r;
	int match_cnt, errors = 0, tests_run = 0, cycles = 0;
	time t0;

	rtcc_core #(.HUND_CYCLES(20), .MS_CYCLES(5)) dut (
		.aclk(aclk), .aresetn(aresetn), .wdt_rst_n(wdt_rst_n), .ref_clk_in(ref_clk_in),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .one_hz_tick(one_hz_tick),
		.pm_match_r(pm_match_r), .irq_req_r(irq_req_r)
	);
	rtcc_far_model #(.REF_HALF(4)) far (.aclk(aclk), .pm_match_r(pm_match_r),
		.ref_clk_in(ref_clk_in), .match_cnt(match_cnt));

	initial
	begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	task automatic finish_test();
		$display("checks %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test

	always @(posedge aclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			errors++;
			finish_test();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			errors++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Both channels offered together, each dropped once taken
	task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		logic ad = 1'b0;
		logic wd = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ad && wd))
		begin
			@(negedge aclk);
			ad = ad || awready;
			wd = wd || wready;
			@(posedge aclk);
			awvalid <= !ad;
			wvalid <= !wd;
		end
		do @(negedge aclk); while (!bvalid);
		rs = bresp;
		@(posedge aclk);
	endtask : axi_wr

	task automatic axi_rd(input logic [ADDR_W-1:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do @(negedge aclk); while (!arready);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (!rvalid);
		rd = rdata;
		rs = rresp;
		@(posedge aclk);
	endtask : axi_rd

	task automatic wr_chk(input logic [ADDR_W-1:0] a, input logic [31:0] d,
		input logic [1:0] er = RESP_OKAY);
		axi_wr(a, d);
		check("bresp", 32'(rs), 32'(er));
	endtask : wr_chk

	task automatic rd_chk(input string n, input logic [ADDR_W-1:0] a, input logic [31:0] e,
		input logic [1:0] er = RESP_OKAY);
		axi_rd(a);
		check(n, rd, e);
		check("rresp", 32'(rs), 32'(er));
	endtask : rd_chk

	task automatic wait_pm();
		hit = 1'b0;
		for (int i = 0; i < 100 && !hit; i++)
		begin
			@(negedge aclk);
			hit = pm_match_r[AL_TIMER] === 1'b1;
		end
		@(posedge aclk);
	endtask : wait_pm

	// Watchdog pulse when hw is low, hardware pulse when high
	task automatic pulse(input logic hw);
		aresetn <= !hw;
		wdt_rst_n <= hw;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		wdt_rst_n <= 1'b1;
		@(posedge aclk);
	endtask : pulse

	initial
	begin
		aresetn = 1'b0;
		wdt_rst_n = 1'b1;
		{awvalid, wvalid, arvalid} = 3'h0;
		{bready, rready} = 2'h3;
		{awaddr, araddr, wdata} = '0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_chk("seconds rst", OFF_SEC_CNT, 32'h0);
		rd_chk("trim rst", OFF_TRIM, 32'h00007fff);
		rd_chk("status rst", OFF_STATUS, 32'h0);
		rd_chk("unmapped", 8'h3c, 32'h0, RESP_SLVERR);
		wr_chk(8'h3c, 32'h1, RESP_SLVERR);
		wr_chk(OFF_TRIM, 32'h3);
		@(posedge one_hz_tick);
		@(posedge one_hz_tick);
		t0 = $time;
		@(posedge one_hz_tick);
		check("tick period", 32'(($time - t0) / 8), 32'h20);
		wr_chk(OFF_SEC_ALM, 32'h20);
		wr_chk(OFF_SEC_CNT, 32'h1f);
		wait_pm();
		check("match off", 32'(hit), 32'h1);
		check("pm count", 32'(match_cnt), 32'h1);
		rd_chk("flag off", OFF_STATUS, 32'h0);
		wr_chk(OFF_SEC_ALM, 32'h40);
		wr_chk(OFF_STATUS, 32'h00000100);
		wr_chk(OFF_SEC_CNT, 32'h3f);
		wait_pm();
		check("match on", 32'(hit), 32'h1);
		check("pm count 2", 32'(match_cnt), 32'h2);
		rd_chk("seconds", OFF_SEC_CNT, 32'h40);
		rd_chk("flag on", OFF_STATUS, 32'h00000101);
		check("irq", 32'(irq_req_r), 32'h1);
		repeat (40) @(posedge aclk);
		rd_chk("flag kept", OFF_STATUS, 32'h00000101);
		rd_chk("one step", OFF_SEC_CNT, 32'h41);
		wr_chk(OFF_STATUS, 32'h00000100);
		rd_chk("w0 keeps", OFF_STATUS, 32'h00000101);
		wr_chk(OFF_STATUS, 32'h00000101);
		rd_chk("w1 clears", OFF_STATUS, 32'h00000100);
		check("irq clr", 32'(irq_req_r), 32'h0);
		rd_chk("elapsed idle", OFF_EL_CNT, 32'h0);
		wr_chk(OFF_STATUS, 32'h00030100);
		repeat (200) @(posedge aclk);
		axi_rd(OFF_EL_CNT);
		check("elapsed runs", 32'(rd != 32'h0), 32'h1);
		axi_rd(OFF_PER_CNT);
		check("periodic runs", 32'(rd != 32'h0), 32'h1);
		wr_chk(OFF_PER_ALM, 32'h4);
		wr_chk(OFF_STATUS, 32'h00032100);
		wr_chk(OFF_PER_CNT, 32'h0);
		repeat (40) @(posedge aclk);
		rd_chk("periodic flag", OFF_STATUS, 32'h00032120);
		check("irq periodic", 32'(irq_req_r), 32'h20);
		pulse(1'b0);
		rd_chk("trim wdt", OFF_TRIM, 32'h3);
		rd_chk("status wdt", OFF_STATUS, 32'h0);
		rd_chk("elapsed wdt", OFF_EL_CNT, 32'h0);
		rd_chk("alarm wdt", OFF_SEC_ALM, 32'h0);
		pulse(1'b1);
		rd_chk("trim hw", OFF_TRIM, 32'h00007fff);
		finish_test();
	end
endmodule : rtcc_core_test
`default_nettype wire
